// >>> core/wopt_pkg.sv
// wopt_pkg: constants and types shared by the wait one-shot pulse timer
package wopt_pkg;
    // ********************************************************
    // register map
    // ********************************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;     // timer_control_reg
    localparam logic [3:0] ADDR_OSCTL = 4'h1;    // oneshot_control_reg
    localparam logic [3:0] ADDR_IOCTL = 4'h2;    // timer_io_control_reg
    localparam logic [3:0] ADDR_PRE = 4'h3;      // prescaler_reg
    localparam logic [3:0] ADDR_SEC = 4'h4;      // secondary_count_reg
    localparam logic [3:0] ADDR_PRI = 4'h5;      // primary_count_reg
    localparam logic [3:0] ADDR_PINSEL = 4'h6;   // pin_select_reg
    localparam logic [3:0] ADDR_SRC = 4'h7;      // count source select
    // ********************************************************
    // field positions
    // ********************************************************
    localparam int CTRL_EN_BIT = 0;     // count_enable_bit
    localparam int CTRL_STAT_BIT = 1;   // counting status, read only
    localparam int CTRL_STOP_BIT = 2;   // forced_stop_bit
    localparam int OS_START_BIT = 0;    // oneshot_start_bit, write 1
    localparam int OS_STOP_BIT = 1;     // oneshot_stop_bit, write 1
    localparam int OS_FLAG_BIT = 2;     // oneshot_active_flag, read only
    localparam int IO_POL_BIT = 0;      // output_polarity_bit
    localparam int IO_TRIG_BIT = 2;     // ext_trigger_enable_bit
    localparam int PS_SEL_BIT = 0;      // output_pin_select_bit
    // ********************************************************
    // reset values
    // ********************************************************
    localparam logic [7:0] RST_PRE = 8'hFF;
    localparam logic [7:0] RST_CNT = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // ********************************************************
    // count sources and phases
    // ********************************************************
    typedef enum logic [1:0] {
        WOPT_SRC_F1 = 2'b00,
        WOPT_SRC_F2 = 2'b01,
        WOPT_SRC_F8 = 2'b10,
        WOPT_SRC_UF = 2'b11
    } wopt_src_t;
    typedef enum logic [1:0] {
        WOPT_IDLE = 2'b00,
        WOPT_ARM = 2'b01,
        WOPT_WAIT = 2'b10,
        WOPT_PULSE = 2'b11
    } wopt_phase_t;
    localparam logic [2:0] DIV8_LAST = 3'h7;
endpackage : wopt_pkg

// >>> core/wopt_tick_gen.sv
// wopt_tick_gen: count-source tick selection
`timescale 1ns/100ps
module wopt_tick_gen (
    input wire logic clk,
    input wire logic rst_n,
    input wire wopt_pkg::wopt_src_t src,
    input wire logic companion_uf,
    output logic tick
);
    // ********************************************************
    // divider state
    // ********************************************************
    typedef struct packed {
        logic [2:0] div;
        logic tick;
    } wopt_tk_t;
    wopt_tk_t s_q;
    wopt_tk_t s_d;

    // free divider and one-cycle tick per chosen source
    always_comb begin
        s_d = s_q;
        s_d.div = s_q.div + 3'h1;
        unique case (src)
            wopt_pkg::WOPT_SRC_F1: s_d.tick = 1'b1;
            wopt_pkg::WOPT_SRC_F2: s_d.tick = s_q.div[0];
            wopt_pkg::WOPT_SRC_F8: s_d.tick = (s_q.div == wopt_pkg::DIV8_LAST);
            wopt_pkg::WOPT_SRC_UF: s_d.tick = companion_uf;
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign tick = s_q.tick;
endmodule : wopt_tick_gen

// >>> core/wopt_timer.sv
// wopt_timer: programmable wait one-shot pulse timer
// Functional notes
// - count source is clk, clk/2, clk/8 or the companion timer underflow
// - wait phase decrements primary; its underflow loads secondary, pulse phase follows
// - secondary underflow reloads primary, ends count, clears the active flag
// - any stop copies reload registers into the counters first
// - wait lasts (prescaler+1)(primary+1) source periods
// - pulse lasts (prescaler+1)(secondary+1) source periods
// - with enable set, a start write or trigger pin edge starts a sequence
// - trigger pin starts the timer only when external trigger enable is set
// - writing 1 to the one-shot stop bit aborts the sequence
// - clearing the count enable bit stops counting
// - setting the forced stop bit halts counting unconditionally
// - interrupt raised as pulse ends, after the secondary underflow
// - one pulse per trigger, only after the full wait
// - reading primary and prescaler returns the live count
// - prescaler and primary writes while stopped update reload and counter; secondary writes update its reload only
// - writes while counting update reload only, taken at that counter's next load (prescaler at its next underflow)
// - polarity bit selects the active level of the pulse
// - pin select bit routes the pulse to one of two pins
// - active flag sets one or two source cycles after a trigger
// - triggers while active are ignored
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/100ps
module wopt_timer (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic ext_trigger_pin,
    input wire logic companion_uf,
    output logic pulse_out_a,
    output logic pulse_out_b,
    output logic timer_irq
);
    // ********************************************************
    // reset release
    // ********************************************************
    logic [1:0] rst_sync_q;
    logic rst_n;

    // two-stage reset release
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        logic enable;
        logic fstop;
        logic polarity;
        logic trig_en;
        logic pin_sel;
        wopt_pkg::wopt_src_t src;
        logic [7:0] pre_rl;
        logic [7:0] pri_rl;
        logic [7:0] sec_rl;
        logic [7:0] pre_cnt;
        logic [7:0] cnt;
        wopt_pkg::wopt_phase_t phase;
        logic arm_seen;
        logic pin_prev;
        logic irq;
        logic out_a;
        logic out_b;
        logic [7:0] rdata;
    } wopt_st_t;
    wopt_st_t s_q;
    wopt_st_t s_d;
    logic tick;

    // count-source tick
    wopt_tick_gen u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .src(s_q.src),
        .companion_uf(companion_uf),
        .tick(tick)
    );

    // ********************************************************
    // helpers
    // ********************************************************
    // write hits a given register
    function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] target);
        wr_hit = wr_en && (a == target);
    endfunction : wr_hit

    // ********************************************************
    // next state
    // ********************************************************
    logic busy;
    logic trig;
    logic stop_now;
    logic pin_edge;

    always_comb begin
        s_d = s_q;
        s_d.irq = 1'b0;
        s_d.rdata = 8'h00;
        busy = (s_q.phase != wopt_pkg::WOPT_IDLE);
        pin_edge = ext_trigger_pin && !s_q.pin_prev;
        s_d.pin_prev = ext_trigger_pin;
        // software start or pin edge, only while idle
        trig = s_q.enable && !s_q.fstop && (s_q.phase == wopt_pkg::WOPT_IDLE)
            && ((wr_hit(addr, wopt_pkg::ADDR_OSCTL) && wdata[wopt_pkg::OS_START_BIT])
            || (s_q.trig_en && pin_edge));
        // control writes
        if (wr_hit(addr, wopt_pkg::ADDR_CTRL)) begin
            s_d.enable = wdata[wopt_pkg::CTRL_EN_BIT];
            s_d.fstop = wdata[wopt_pkg::CTRL_STOP_BIT];
        end
        if (wr_hit(addr, wopt_pkg::ADDR_IOCTL)) begin
            s_d.polarity = wdata[wopt_pkg::IO_POL_BIT];
            s_d.trig_en = wdata[wopt_pkg::IO_TRIG_BIT];
        end
        if (wr_hit(addr, wopt_pkg::ADDR_PINSEL)) begin
            s_d.pin_sel = wdata[wopt_pkg::PS_SEL_BIT];
        end
        if (wr_hit(addr, wopt_pkg::ADDR_SRC)) begin
            s_d.src = wopt_pkg::wopt_src_t'(wdata[1:0]);
        end
        // count registers: reload always, prescaler and primary counter too when stopped
        if (wr_hit(addr, wopt_pkg::ADDR_PRE)) begin
            s_d.pre_rl = wdata;
            if (!busy) begin
                s_d.pre_cnt = wdata;
            end
        end
        if (wr_hit(addr, wopt_pkg::ADDR_SEC)) begin
            s_d.sec_rl = wdata;
        end
        if (wr_hit(addr, wopt_pkg::ADDR_PRI)) begin
            s_d.pri_rl = wdata;
            if (!busy) begin
                s_d.cnt = wdata;
            end
        end
        // sequence
        unique case (s_q.phase)
            wopt_pkg::WOPT_IDLE: begin
                if (trig) begin
                    s_d.phase = wopt_pkg::WOPT_ARM;
                    s_d.arm_seen = 1'b0;
                end
            end
            wopt_pkg::WOPT_ARM: begin
                // flag rises on the second source tick
                if (tick) begin
                    s_d.arm_seen = 1'b1;
                    if (s_q.arm_seen) begin
                        s_d.phase = wopt_pkg::WOPT_WAIT;
                        s_d.pre_cnt = s_q.pre_rl;
                        s_d.cnt = s_q.pri_rl;
                    end
                end
            end
            wopt_pkg::WOPT_WAIT, wopt_pkg::WOPT_PULSE: begin
                if (tick) begin
                    if (s_q.pre_cnt != 8'h00) begin
                        s_d.pre_cnt = s_q.pre_cnt - 8'h01;
                    end else begin
                        s_d.pre_cnt = s_q.pre_rl;
                        if (s_q.cnt != 8'h00) begin
                            s_d.cnt = s_q.cnt - 8'h01;
                        end else if (s_q.phase == wopt_pkg::WOPT_WAIT) begin
                            s_d.cnt = s_q.sec_rl;
                            s_d.phase = wopt_pkg::WOPT_PULSE;
                        end else begin
                            s_d.cnt = s_q.pri_rl;
                            s_d.phase = wopt_pkg::WOPT_IDLE;
                            s_d.irq = 1'b1;
                        end
                    end
                end
            end
        endcase
        // stop requests end any sequence with a reload
        stop_now = (wr_hit(addr, wopt_pkg::ADDR_OSCTL) && wdata[wopt_pkg::OS_STOP_BIT])
            || (wr_hit(addr, wopt_pkg::ADDR_CTRL) && !wdata[wopt_pkg::CTRL_EN_BIT])
            || s_q.fstop;
        if (stop_now && busy) begin
            s_d.phase = wopt_pkg::WOPT_IDLE;
            s_d.pre_cnt = s_q.pre_rl;
            s_d.cnt = s_q.pri_rl;
        end
        // pin drive, inactive outside the pulse phase
        s_d.out_a = s_q.polarity;
        s_d.out_b = s_q.polarity;
        if (s_d.phase == wopt_pkg::WOPT_PULSE) begin
            if (s_q.pin_sel) begin
                s_d.out_b = !s_q.polarity;
            end else begin
                s_d.out_a = !s_q.polarity;
            end
        end
        // read port
        if (rd_en) begin
            unique case (addr)
                wopt_pkg::ADDR_CTRL: begin
                    s_d.rdata[wopt_pkg::CTRL_EN_BIT] = s_q.enable;
                    s_d.rdata[wopt_pkg::CTRL_STAT_BIT] = busy;
                    s_d.rdata[wopt_pkg::CTRL_STOP_BIT] = s_q.fstop;
                end
                wopt_pkg::ADDR_OSCTL: begin
                    s_d.rdata[wopt_pkg::OS_FLAG_BIT] =
                        (s_q.phase == wopt_pkg::WOPT_WAIT) || (s_q.phase == wopt_pkg::WOPT_PULSE);
                end
                wopt_pkg::ADDR_IOCTL: begin
                    s_d.rdata[wopt_pkg::IO_POL_BIT] = s_q.polarity;
                    s_d.rdata[wopt_pkg::IO_TRIG_BIT] = s_q.trig_en;
                end
                wopt_pkg::ADDR_PRE: s_d.rdata = s_q.pre_cnt;
                wopt_pkg::ADDR_SEC: s_d.rdata = s_q.sec_rl;
                wopt_pkg::ADDR_PRI: s_d.rdata = s_q.cnt;
                wopt_pkg::ADDR_PINSEL: s_d.rdata[wopt_pkg::PS_SEL_BIT] = s_q.pin_sel;
                wopt_pkg::ADDR_SRC: s_d.rdata[1:0] = s_q.src;
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    // ********************************************************
    // state register
    // ********************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{enable: 1'b0, fstop: 1'b0, polarity: 1'b0, trig_en: 1'b0,
                     pin_sel: 1'b0, src: wopt_pkg::WOPT_SRC_F1,
                     pre_rl: wopt_pkg::RST_PRE, pri_rl: wopt_pkg::RST_CNT,
                     sec_rl: wopt_pkg::RST_CNT, pre_cnt: wopt_pkg::RST_PRE,
                     cnt: wopt_pkg::RST_CNT, phase: wopt_pkg::WOPT_IDLE,
                     arm_seen: 1'b0, pin_prev: 1'b0, irq: 1'b0,
                     out_a: 1'b0, out_b: 1'b0, rdata: wopt_pkg::RST_ZERO};
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign pulse_out_a = s_q.out_a;
    assign pulse_out_b = s_q.out_b;
    assign timer_irq = s_q.irq;
endmodule : wopt_timer

// >>> verification/wopt_timer_props.sv
// wopt_timer_props: port-level checks for the wait one-shot timer
`timescale 1ns/100ps
module wopt_timer_props (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic ext_trigger_pin,
    input wire logic companion_uf,
    input wire logic pulse_out_a,
    input wire logic pulse_out_b,
    input wire logic timer_irq
);
    logic pol_q, sel_q, stop_q, act;
    // shadow copies of polarity, pin select and forced stop
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pol_q <= 1'h0;
            sel_q <= 1'h0;
            stop_q <= 1'h0;
        end else if (wr_en) begin
            if (addr == wopt_pkg::ADDR_IOCTL) pol_q <= wdata[wopt_pkg::IO_POL_BIT];
            if (addr == wopt_pkg::ADDR_PINSEL) sel_q <= wdata[wopt_pkg::PS_SEL_BIT];
            if (addr == wopt_pkg::ADDR_CTRL) stop_q <= wdata[wopt_pkg::CTRL_STOP_BIT];
        end
    end
    // pulse seen at its active level on the selected pin
    assign act = (sel_q ? pulse_out_b : pulse_out_a) ^ pol_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_fall;
        !act && $past(act);
    endsequence
    sequence s_ends;
        ##[1:3] !act;
    endsequence
    a_irq_single: assert property (timer_irq |=> !timer_irq)
        else $error("interrupt longer than one cycle");
    a_irq_pulse_end: assert property (timer_irq |-> s_fall)
        else $error("interrupt not at end of pulse");
    a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
        else $error("read data outside read cycle");
    a_unmapped_zero: assert property (rd_en && addr[3] |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_osstop_ends: assert property (wr_en && addr == wopt_pkg::ADDR_OSCTL
        && wdata[wopt_pkg::OS_STOP_BIT] |-> s_ends)
        else $error("one-shot stop left pulse active");
    a_disable_ends: assert property (wr_en && addr == wopt_pkg::ADDR_CTRL
        && !wdata[wopt_pkg::CTRL_EN_BIT] |-> s_ends)
        else $error("disable left pulse active");
    a_force_ends: assert property (wr_en && addr == wopt_pkg::ADDR_CTRL
        && wdata[wopt_pkg::CTRL_STOP_BIT] |-> s_ends)
        else $error("forced stop left pulse active");
    a_stop_idle: assert property (stop_q && $past(stop_q, 3) |-> !act && !timer_irq)
        else $error("activity while forced stop held");
endmodule : wopt_timer_props
bind wopt_timer wopt_timer_props u_props (.clk(clk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .ext_trigger_pin(ext_trigger_pin), .companion_uf(companion_uf),
    .pulse_out_a(pulse_out_a), .pulse_out_b(pulse_out_b), .timer_irq(timer_irq));

// >>> verification/wopt_far_end.sv
// wopt_far_end: trigger source, companion underflows and pulse load
`timescale 1ns/100ps
module wopt_far_end (
    input wire logic clk,
    input wire logic fire,
    input wire logic use_pin,
    input wire logic pol,
    input wire logic sel,
    input wire logic out_a,
    input wire logic out_b,
    output logic trig_pin,
    output logic comp_uf,
    output logic [15:0] width,
    output logic [15:0] delay,
    output logic [7:0] pulses
);
    logic [2:0] div_q = 3'h0;
    logic [3:0] hold_q = 4'h0;
    logic [15:0] run_q = 16'h0;
    logic [15:0] since_q = 16'h0;
    logic act;
    logic act_q = 1'h0;
    assign act = (sel ? out_b : out_a) ^ pol;
    initial begin
        trig_pin = 1'h0;
        comp_uf = 1'h0;
        width = 16'h0;
        delay = 16'h0;
        pulses = 8'h0;
    end
    // underflow every fifth clock, four-clock trigger, pulse timing
    always @(posedge clk) begin
        div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
        comp_uf <= (div_q == 3'h4);
        hold_q <= (fire && use_pin) ? 4'h4 : hold_q - {3'h0, hold_q != 4'h0};
        trig_pin <= (hold_q != 4'h0);
        since_q <= fire ? 16'h1 : since_q + 16'h1;
        act_q <= act;
        run_q <= act ? run_q + 16'h1 : 16'h0;
        if (act && !act_q) begin
            delay <= since_q;
            pulses <= pulses + 8'h1;
        end
        if (!act && act_q) begin
            width <= run_q;
        end
    end
endmodule : wopt_far_end

// >>> verification/wopt_timer_bench.sv
// wopt_timer_bench: register-driven tests of the wait one-shot timer
`timescale 1ns/100ps
module wopt_timer_bench;
    logic clk, arst_n, wr_en, rd_en, trig_pin, comp_uf, out_a, out_b, irq;
    logic fire, use_pin, pol, sel, got;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, v, pulses, p0;
    logic [15:0] width, delay;
    int miscompares, cmp_count;
    int divs[4] = '{1, 2, 8, 5};
    logic [3:0] st_a[3] = '{wopt_pkg::ADDR_CTRL, wopt_pkg::ADDR_CTRL, wopt_pkg::ADDR_OSCTL};
    logic [7:0] st_d[3] = '{8'h00, 8'h05, 8'h02};
    wopt_timer DUT (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .ext_trigger_pin(trig_pin), .companion_uf(comp_uf),
        .pulse_out_a(out_a), .pulse_out_b(out_b), .timer_irq(irq));
    wopt_far_end u_far (.clk(clk), .fire(fire), .use_pin(use_pin), .pol(pol), .sel(sel),
        .out_a(out_a), .out_b(out_b), .trig_pin(trig_pin), .comp_uf(comp_uf),
        .width(width), .delay(delay), .pulses(pulses));
    // clock
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'h0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd_en <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'h0;
        #1 d = rdata;
    endtask : rd
    task automatic trig(input logic pin_mode);
        @(posedge clk);
        fire <= 1'h1;
        use_pin <= pin_mode;
        wr_en <= !pin_mode;
        addr <= wopt_pkg::ADDR_OSCTL;
        wdata <= 8'h01;
        @(posedge clk);
        fire <= 1'h0;
        wr_en <= 1'h0;
    endtask : trig
    task automatic wait_irq(input int lim);
        got = 1'h0;
        for (int i = 0; i < lim && !got; i++) begin
            @(posedge clk);
            #1 got = (irq === 1'h1);
        end
    endtask : wait_irq
    task automatic setup(input logic [1:0] src, input logic [7:0] pre, sec, pri);
        wr(wopt_pkg::ADDR_CTRL, 8'h00);
        wr(wopt_pkg::ADDR_SRC, {6'h00, src});
        wr(wopt_pkg::ADDR_PRE, pre);
        wr(wopt_pkg::ADDR_SEC, sec);
        wr(wopt_pkg::ADDR_PRI, pri);
        wr(wopt_pkg::ADDR_CTRL, 8'h01);
        // enabled but not counting until a trigger arrives
        rd(wopt_pkg::ADDR_CTRL, v);
        check("ctrl", 16'(v), 16'h0001);
    endtask : setup
    task automatic shot(input logic pin_mode, input int pre, sec, pri, div);
        int wa;
        wa = (pre + 1) * (pri + 1) * div;
        p0 = pulses;
        trig(pin_mode);
        wait_irq(4000);
        check("irq", 16'(got), 16'h1);
        @(posedge clk);
        #1 check("width", width, 16'((pre + 1) * (sec + 1) * div));
        check("pulses", 16'(pulses), 16'(p0 + 8'h1));
        check("wait", 16'(delay >= wa && delay <= wa + 5 * div + 6), 16'h1);
    endtask : shot
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    // watchdog
    initial begin
        #300000;
        miscompares++;
        $display("watchdog expired");
        final_report();
    end
    // test sequence
    initial begin
        {arst_n, wr_en, rd_en, fire, use_pin, pol, sel} = 7'h00;
        addr = 4'h0;
        wdata = 8'h00;
        repeat (4) @(posedge clk);
        arst_n <= 1'h1;
        repeat (3) @(posedge clk);
        rd(wopt_pkg::ADDR_PRE, v);
        check("pre reset", 16'(v), 16'(wopt_pkg::RST_PRE));
        rd(4'hF, v);
        check("unmapped", 16'(v), 16'h0);
        $display("reset test done");
        for (int s = 0; s < 4; s++) begin
            setup(s[1:0], 8'h01, 8'h02, 8'h03);
            shot(1'h0, 1, 2, 3, divs[s]);
            rd(wopt_pkg::ADDR_PRI, v);
            check("reload", 16'(v), 16'h3);
            rd(wopt_pkg::ADDR_OSCTL, v);
            check("flag", 16'(v[wopt_pkg::OS_FLAG_BIT]), 16'h0);
        end
        $display("source test done");
        setup(wopt_pkg::WOPT_SRC_F1, 8'h00, 8'h03, 8'h04);
        wr(wopt_pkg::ADDR_IOCTL, 8'h01);
        wr(wopt_pkg::ADDR_PINSEL, 8'h01);
        pol <= 1'h1;
        sel <= 1'h1;
        // let the load model settle on the new polarity before counting
        #1 p0 = pulses;
        trig(1'h1);
        wait_irq(300);
        check("pin off", 16'(got), 16'h0);
        check("pin off pulses", 16'(pulses), 16'(p0));
        wr(wopt_pkg::ADDR_IOCTL, 8'h05);
        shot(1'h1, 0, 3, 4, 1);
        $display("pin test done");
        setup(wopt_pkg::WOPT_SRC_F1, 8'h00, 8'h10, 8'h04);
        p0 = pulses;
        trig(1'h0);
        repeat (12) @(posedge clk);
        wr(wopt_pkg::ADDR_SEC, 8'h05);
        trig(1'h0);
        wait_irq(200);
        @(posedge clk);
        #1 check("old sec", width, 16'h11);
        check("one pulse", 16'(pulses), 16'(p0 + 8'h1));
        shot(1'h0, 0, 5, 4, 1);
        $display("reload test done");
        for (int k = 0; k < 3; k++) begin
            // long pulse phase, so each stop cuts an active pulse
            setup(wopt_pkg::WOPT_SRC_F1, 8'h00, 8'h40, 8'h04);
            trig(1'h0);
            repeat (20) @(posedge clk);
            rd(wopt_pkg::ADDR_PRI, v);
            check("live", 16'(v < 8'h40), 16'h1);
            rd(wopt_pkg::ADDR_OSCTL, v);
            check("running flag", 16'(v[wopt_pkg::OS_FLAG_BIT]), 16'h1);
            wr(st_a[k], st_d[k]);
            wait_irq(150);
            check("stopped", 16'(got), 16'h0);
            check("idle pins", 16'({out_a, out_b}), 16'h0003);
            rd(wopt_pkg::ADDR_PRI, v);
            check("stop reload", 16'(v), 16'h4);
        end
        $display("stop test done");
        final_report();
    end
endmodule : wopt_timer_bench
